//--- verilog/sfmt_pkg.sv
// shared constants of the serial transmit path: register map, field
// positions, reset values, line states and default bit timing.
// assumes a 32-bit APB slave port with a 12-bit byte address.
`default_nettype none
package sfmt_pkg;
   localparam int ADDR_W = 12;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_FORMAT  = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_CONTROL = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_HOLD    = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_FLAG    = 12'h00C;

   // frame_format fields
   localparam int FMT_SYNC_BIT = 7;
   localparam int FMT_CHR_BIT  = 6;
   localparam int FMT_PE_BIT   = 5;
   localparam int FMT_ODD_BIT  = 4;
   localparam int FMT_STOP_BIT = 3;
   localparam int FMT_MP_BIT   = 2;
   localparam int FMT_CKS_LO   = 0;

   // control and serial_flag_reg fields
   localparam int CTL_TXEN_BIT  = 5;
   localparam int FLG_EMPTY_BIT = 7;
   localparam int FLG_TEND_BIT  = 2;
   localparam int FLG_MPBT_BIT  = 0;

   // reset values
   localparam logic [7:0] HOLD_RST = 8'hFF;
   localparam logic [7:0] FMT_RST  = 8'h00;
   localparam logic [7:0] CTL_RST  = 8'h00;

   // data bits minus one
   localparam logic [2:0] BITS8_LEFT = 3'h7;
   localparam logic [2:0] BITS7_LEFT = 3'h6;

   // prescaler counter width, enough for the divide-by-64 tap
   localparam int PRE_W = 6;

   // prescaled ticks per half bit
   localparam int HALF_BIT_DEF = 1;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_DATA,
      ST_PAR,
      ST_STOP
   } sfmt_state_t;
endpackage
`default_nettype wire

//--- verilog/sfmt_prescale.sv
// baud generator input clock: one-cycle enable at pclk/1, /4, /16, /64.
// assumes the select may change at any time; a change only shifts phase.
`timescale 1ns/100ps
`default_nettype none
module sfmt_prescale
   import sfmt_pkg::*;
(
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // divide select
   input  wire logic [1:0] sel,
   // enable pulse
   output logic            tick
);
   logic [PRE_W-1:0] cnt;

   function automatic logic [PRE_W-1:0] div_mask(input logic [1:0] s);
      case (s)
         2'h0:    div_mask = 6'h00;
         2'h1:    div_mask = 6'h03;
         2'h2:    div_mask = 6'h0F;
         default: div_mask = 6'h3F;
      endcase
   endfunction

   wire logic [PRE_W-1:0] mask = div_mask(sel);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + 6'h01;
      end
   end

   assign tick = (cnt & mask) == mask;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_div_one: assert property (sel == 2'h0 |-> tick)
      else $error("prescaler not passing pclk");
   // a switch to divide-by-one ticks at once, so only a held divider counts
   chk_div_gap: assert property (
      (sel != 2'h0 && tick) ##1 sel != 2'h0 |-> !tick)
      else $error("prescaler ticks back to back");
endmodule
`default_nettype wire

//--- verilog/sfmt_tx.sv
// transmit path and frame format of one serial channel, APB slave.
// assumes APB3 master, pclk 125 MHz, standby as a synchronous level.
`timescale 1ns/100ps
`default_nettype none
module sfmt_tx
   import sfmt_pkg::*;
#(
   parameter int HALF_BIT_TICKS = HALF_BIT_DEF
)(
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // power state
   input  wire logic              standby,
   // serial line
   output logic                   txd,
   output logic                   ser_clk_out
);
   localparam int PH_W = (HALF_BIT_TICKS > 1) ? $clog2(2 * HALF_BIT_TICKS)
                                              : 1;
   localparam logic [PH_W-1:0] PH_HALF = PH_W'(HALF_BIT_TICKS);
   localparam logic [PH_W-1:0] PH_LAST = PH_W'(2 * HALF_BIT_TICKS - 1);

   if (HALF_BIT_TICKS < 1 || HALF_BIT_TICKS > 128) begin : g_bad_half
      $error("HALF_BIT_TICKS must lie in 1..128");
   end

   logic [7:0]       frame_format;
   logic [7:0]       control;
   logic [7:0]       tx_holding;
   logic             holding_empty_flag;
   logic             mp_bit_tx;
   sfmt_state_t      state;
   sfmt_state_t      next_state;
   logic [7:0]       tx_shift_reg;
   logic [7:0]       next_tx_shift_reg;
   logic [2:0]       bits_left;
   logic [2:0]       next_bits_left;
   logic             stop_left;
   logic             next_stop_left;
   logic             extra_bit;
   logic             next_extra_bit;
   logic [PH_W-1:0]  phase;
   logic [PH_W-1:0]  next_phase;
   logic             tick;
   logic [7:0]       flag_byte;

   // bus decode
   wire logic acc      = psel & penable;
   wire logic setup    = psel & ~penable;
   wire logic sel_fmt  = paddr == OFF_FORMAT;
   wire logic sel_ctl  = paddr == OFF_CONTROL;
   wire logic sel_hold = paddr == OFF_HOLD;
   wire logic sel_flag = paddr == OFF_FLAG;
   wire logic mapped   = sel_fmt | sel_ctl | sel_hold | sel_flag;
   wire logic wr_fmt   = acc & pwrite & sel_fmt;
   wire logic wr_ctl   = acc & pwrite & sel_ctl;
   wire logic wr_hold  = acc & pwrite & sel_hold;
   wire logic wr_flag  = acc & pwrite & sel_flag;
   wire logic flag_clr = wr_flag & ~pwdata[FLG_EMPTY_BIT];

   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   // format decode
   wire logic tx_enable = control[CTL_TXEN_BIT];
   wire logic is_sync   = frame_format[FMT_SYNC_BIT];
   wire logic char7     = ~is_sync & frame_format[FMT_CHR_BIT];
   wire logic mp_on     = ~is_sync & frame_format[FMT_MP_BIT];
   wire logic par_on    = ~is_sync & frame_format[FMT_PE_BIT]
                          & ~mp_on;
   wire logic odd_par   = frame_format[FMT_ODD_BIT];
   // a receiver checks only the first stop, so the second is slack
   wire logic two_stop  = frame_format[FMT_STOP_BIT];
   wire logic [7:0] hold_masked = char7 ? {1'b0, tx_holding[6:0]}
                                        : tx_holding;
   wire logic parity_val = ^hold_masked ^ odd_par;

   // sequencing
   wire logic bit_end    = tick & (phase == PH_LAST);
   wire logic ready_load = tx_enable & ~holding_empty_flag & ~standby;
   wire logic last_bit   = (state == ST_STOP & ~stop_left)
                           | (state == ST_DATA & is_sync
                              & bits_left == 3'h0);
   wire logic load_now   = ready_load
                           & (state == ST_IDLE | (bit_end & last_bit));
   wire logic tx_end     = (state == ST_IDLE) & holding_empty_flag;
   // disabling the transmitter pins the flag at one
   wire logic next_empty = ~tx_enable | load_now
                           | (holding_empty_flag & ~flag_clr);

   sfmt_prescale u_prescale (
      .pclk    (pclk),
      .presetn (presetn),
      .sel     (frame_format[FMT_CKS_LO +: 2]),
      .tick    (tick)
   );

   function automatic logic line_level(input sfmt_state_t s,
                                       input logic d,
                                       input logic x);
      case (s)
         ST_START: line_level = 1'b0;
         ST_DATA:  line_level = d;
         ST_PAR:   line_level = x;
         default:  line_level = 1'b1;
      endcase
   endfunction

   always_comb begin
      flag_byte                = 8'h00;
      flag_byte[FLG_EMPTY_BIT] = holding_empty_flag;
      flag_byte[FLG_TEND_BIT]  = tx_end;
      flag_byte[FLG_MPBT_BIT]  = mp_bit_tx;
   end

   // shift register is not in the read mux at all
   wire logic [7:0] rd_byte = sel_fmt  ? frame_format :
                              sel_ctl  ? control      :
                              sel_hold ? tx_holding   :
                              sel_flag ? flag_byte    : 8'h00;

   always_comb begin
      next_state        = state;
      next_tx_shift_reg = tx_shift_reg;
      next_bits_left    = bits_left;
      next_stop_left    = stop_left;
      next_extra_bit    = extra_bit;
      next_phase        = phase;
      if (tick) begin
         next_phase = (phase == PH_LAST) ? '0 : phase + PH_W'(1);
      end
      if (bit_end) begin
         case (state)
            ST_START: begin
               next_state = ST_DATA;
            end
            ST_DATA: begin
               next_tx_shift_reg = {1'b0, tx_shift_reg[7:1]};
               next_bits_left    = bits_left - 3'h1;
               if (bits_left == 3'h0) begin
                  if (is_sync) begin
                     next_state = ST_IDLE;
                  end else if (par_on | mp_on) begin
                     next_state = ST_PAR;
                  end else begin
                     next_state = ST_STOP;
                  end
               end
            end
            ST_PAR: begin
               next_state = ST_STOP;
            end
            ST_STOP: begin
               next_stop_left = 1'b0;
               if (!stop_left) begin
                  next_state = ST_IDLE;
               end
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
      if (load_now) begin
         next_tx_shift_reg = tx_holding;
         next_bits_left    = char7 ? BITS7_LEFT : BITS8_LEFT;
         next_stop_left    = two_stop;
         next_extra_bit    = mp_on ? mp_bit_tx : parity_val;
         next_state        = is_sync ? ST_DATA : ST_START;
         next_phase        = '0;
      end
      if (standby | ~tx_enable) begin
         next_state = ST_IDLE;
         next_phase = '0;
      end
      if (next_state == ST_IDLE) begin
         next_phase = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state        <= ST_IDLE;
         tx_shift_reg <= 8'h00;
         bits_left    <= 3'h0;
         stop_left    <= 1'b0;
         extra_bit    <= 1'b0;
         phase        <= '0;
         txd          <= 1'b1;
         ser_clk_out  <= 1'b1;
      end else begin
         state        <= next_state;
         tx_shift_reg <= next_tx_shift_reg;
         bits_left    <= next_bits_left;
         stop_left    <= next_stop_left;
         extra_bit    <= next_extra_bit;
         phase        <= next_phase;
         txd          <= line_level(next_state, next_tx_shift_reg[0],
                                    next_extra_bit);
         // clock falls for the first half bit, receiver samples on rise
         ser_clk_out  <= ~(is_sync & next_state == ST_DATA
                           & next_phase < PH_HALF);
      end
   end

   // standby restores reset values, the same ones that presetn loads
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_holding         <= HOLD_RST;
         frame_format       <= FMT_RST;
         control            <= CTL_RST;
         mp_bit_tx          <= 1'b0;
         holding_empty_flag <= 1'b1;
      end else if (standby) begin
         tx_holding         <= HOLD_RST;
         frame_format       <= FMT_RST;
         control            <= CTL_RST;
         mp_bit_tx          <= 1'b0;
         holding_empty_flag <= 1'b1;
      end else begin
         if (wr_hold) begin
            tx_holding <= pwdata[7:0];
         end
         if (wr_fmt) begin
            frame_format <= pwdata[7:0];
         end
         if (wr_ctl) begin
            control <= pwdata[7:0];
         end
         if (wr_flag) begin
            mp_bit_tx <= pwdata[FLG_MPBT_BIT];
         end
         holding_empty_flag <= next_empty;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup & ~pwrite) begin
         prdata <= {24'h00_0000, rd_byte};
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_lsb_first: assert property (
      (state == ST_DATA && bit_end && bits_left != 3'h0
       && tx_enable && !standby) |=> txd == $past(tx_shift_reg[1]))
      else $error("data bit not sent in lsb-first order");

   chk_reload_end: assert property (
      (bit_end && last_bit && ready_load && tx_enable)
      |=> state != ST_IDLE && holding_empty_flag)
      else $error("no reload at end of character");

   chk_no_load: assert property (
      (state == ST_IDLE && holding_empty_flag) |=> state == ST_IDLE)
      else $error("load taken with empty holding register");

   chk_shift_hidden: assert property (
      (state == ST_IDLE && !load_now) |=> $stable(tx_shift_reg))
      else $error("shift register changed without a load");

   chk_load_copy: assert property (
      (state == ST_IDLE && ready_load && tx_enable)
      |=> tx_shift_reg == $past(tx_holding) && state != ST_IDLE)
      else $error("holding register not moved into shift register");

   chk_hold_write: assert property (
      (wr_hold && !standby) |=> tx_holding == $past(pwdata[7:0]))
      else $error("holding write lost");

   chk_hold_standby: assert property (
      standby |=> tx_holding == HOLD_RST)
      else $error("holding register not set to all ones");

   chk_fmt_standby: assert property (
      standby |=> frame_format == FMT_RST && state == ST_IDLE)
      else $error("format register not cleared");

   chk_sync_nostart: assert property (
      (load_now && is_sync) |=> state == ST_DATA && txd == tx_shift_reg[0])
      else $error("synchronous character began with a start bit");

   chk_seven_bits: assert property (
      (load_now && char7) |=> bits_left == BITS7_LEFT)
      else $error("seven-bit length not applied");

   chk_parity_val: assert property (
      (load_now && par_on) |=> extra_bit == (^$past(hold_masked)
                                              ^ $past(odd_par)))
      else $error("parity bit wrong");

   chk_stop_high: assert property (
      state == ST_STOP |-> txd)
      else $error("stop bit not high");

   chk_empty_held: assert property (
      !tx_enable |=> holding_empty_flag)
      else $error("empty flag not held while disabled");

   chk_start_low: assert property (
      (state == ST_START |-> !txd) and (state == ST_IDLE |-> txd))
      else $error("start or idle line level wrong");
endmodule
`default_nettype wire

//--- dv/sfmt_line_rx.sv
// far-end receiver model: samples the serial line, hands the bench the
// captured frame (async: start bit in bit 0) and a running frame count.
// assumes the bench sets mode, bit time and bit count before each frame.
`timescale 1ns/100ps
`default_nettype none
module sfmt_line_rx (
   // clock and line
   input  wire logic        pclk,
   input  wire logic        txd,
   input  wire logic        ser_clk_out,
   // frame shape
   input  wire logic        sync_mode,
   input  wire logic [9:0]  bit_cycles,
   input  wire logic [3:0]  n_bits,
   // capture
   output var logic  [11:0] frame,
   output var int           frames
);
   logic [11:0] acc;
   logic [11:0] sacc;
   logic [3:0]  cnt;
   initial begin
      frames = 0;
      sacc = '0;
      cnt = '0;
   end
   // sample at the falling pclk so a bit edge never races the sample
   initial forever begin
      do @(negedge txd); while (sync_mode);
      acc = '0;
      repeat (bit_cycles / 2) @(negedge pclk);
      for (int i = 0; i < n_bits; i++) begin
         acc[i] = txd;
         if (i + 1 < n_bits) repeat (bit_cycles) @(negedge pclk);
      end
      frame = acc;
      frames++;
   end
   // sync data is taken on the rising serial clock, mid bit
   always @(posedge ser_clk_out) begin
      if (sync_mode) begin
         sacc[cnt] = txd;
         cnt = cnt + 4'h1;
         if (cnt == n_bits) begin
            frame = sacc;
            frames++;
            cnt = '0;
         end
      end
   end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench of the serial transmit path over APB.
// assumes HALF_BIT_TICKS of 2, so a bit is 4 prescaled ticks.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import sfmt_pkg::*;
   typedef struct {
      logic [7:0]  fmt;
      logic [7:0]  flg;
      logic [7:0]  dat;
      logic [3:0]  nb;
      logic [11:0] exp;
   } sfmt_row_t;
   localparam int NROW = 11;
   sfmt_row_t rows [NROW] = '{
      '{8'h00, 8'h00, 8'hA5, 4'hA, 12'h34A},
      '{8'h08, 8'h00, 8'h3C, 4'hB, 12'h678},
      '{8'h60, 8'h00, 8'h81, 4'hA, 12'h302},
      '{8'h30, 8'h00, 8'h03, 4'hB, 12'h606},
      '{8'h20, 8'h00, 8'h03, 4'hB, 12'h406},
      '{8'h34, 8'h00, 8'h00, 4'hB, 12'h400},
      '{8'h24, 8'h01, 8'h00, 4'hB, 12'h600},
      '{8'h01, 8'h00, 8'h5A, 4'hA, 12'h2B4},
      '{8'h02, 8'h00, 8'hC3, 4'hA, 12'h386},
      '{8'h03, 8'h00, 8'h0F, 4'hA, 12'h21E},
      '{8'hFC, 8'h00, 8'h96, 4'h8, 12'h096}
   };
   logic              pclk;
   logic              presetn    = 1'b0;
   logic              psel       = 1'b0;
   logic              penable    = 1'b0;
   logic              pwrite     = 1'b0;
   logic [ADDR_W-1:0] paddr      = '0;
   logic [31:0]       pwdata     = '0;
   logic              standby    = 1'b0;
   logic              sync_mode  = 1'b0;
   logic [9:0]        bit_cycles = 10'h4;
   logic [3:0]        n_bits     = 4'hA;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              txd;
   logic              ser_clk_out;
   logic [11:0]       frame;
   logic [31:0]       rd_data;
   logic              rd_err;
   int                frames;
   int                n_fail = 0;
   int                cmp_count = 0;
   int                f0;
   int                k;

   sfmt_tx #(.HALF_BIT_TICKS(2)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .standby(standby), .txd(txd),
      .ser_clk_out(ser_clk_out));
   sfmt_line_rx far_end (.pclk(pclk), .txd(txd),
      .ser_clk_out(ser_clk_out), .sync_mode(sync_mode),
      .bit_cycles(bit_cycles), .n_bits(n_bits), .frame(frame),
      .frames(frames));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task automatic tally_and_finish;
      if (n_fail == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one idle edge first, so back-to-back calls never drive psel twice
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         n_fail++;
         tally_and_finish();
      end
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask

   task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a,
                         input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd_data);
   endtask

   task automatic wait_frames(input int n);
      for (int i = 0; i < 4000 && frames < n; i++) @(posedge pclk);
      if (frames < n) begin
         n_fail++;
         tally_and_finish();
      end
   endtask

   task automatic chk_rst;
      rd_chk("format", OFF_FORMAT, 32'h0);
      rd_chk("holding", OFF_HOLD, 32'hFF);
      rd_chk("flag", OFF_FLAG, 32'h84);
   endtask

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int r = 0; r < NROW; r++) begin
         f0 = frames;
         sync_mode <= rows[r].fmt[7];
         n_bits <= rows[r].nb;
         bit_cycles <= 10'h4 << (2 * rows[r].fmt[1:0]);
         wr(OFF_CONTROL, 8'h00);
         wr(OFF_FORMAT, rows[r].fmt);
         wr(OFF_CONTROL, 8'h20);
         wr(OFF_HOLD, rows[r].dat);
         wr(OFF_FLAG, rows[r].flg);
         rd_chk("holding", OFF_HOLD, {24'h0, rows[r].dat});
         rd_chk("format", OFF_FORMAT, {24'h0, rows[r].fmt});
         chk("mapped error", 32'h0, {31'h0, rd_err});
         wait_frames(f0 + 1);
         chk("frame", {20'h0, rows[r].exp}, {20'h0, frame});
         repeat (40) @(posedge pclk);
         chk("serial clock", 32'h1, {31'h0, ser_clk_out});
         chk("frames", f0 + 1, frames);
      end
      // second reset in mid-run
      wr(OFF_FORMAT, 8'h08);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("line in reset", 32'h1, {31'h0, txd});
      presetn <= 1'b1;
      chk_rst();
      // shift register has no address
      wr(12'h010, 8'h5A);
      chk("slave error", 32'h1, {31'h0, rd_err});
      rd_chk("unmapped", 12'h010, 32'h0);
      // refill while shifting: no idle gap
      sync_mode <= 1'b0;
      n_bits <= 4'hA;
      bit_cycles <= 10'h4;
      wr(OFF_CONTROL, 8'h20);
      f0 = frames;
      wr(OFF_HOLD, 8'h11);
      wr(OFF_FLAG, 8'h00);
      wr(OFF_HOLD, 8'h22);
      wr(OFF_FLAG, 8'h00);
      wait_frames(f0 + 1);
      chk("first frame", 32'h222, {20'h0, frame});
      // line looked at on the falling edge, clear of the edge that drives it
      for (k = 0; k < 40 && txd !== 1'b0; k++) @(negedge pclk);
      chk("idle gap", 32'h1, 32'(k <= 3));
      wait_frames(f0 + 2);
      chk("second frame", 32'h244, {20'h0, frame});
      // disable in mid character
      wr(OFF_HOLD, 8'h55);
      wr(OFF_FLAG, 8'h00);
      repeat (6) @(posedge pclk);
      wr(OFF_CONTROL, 8'h00);
      wr(OFF_FLAG, 8'h00);
      rd_chk("flag tx off", OFF_FLAG, 32'h84);
      chk("line after abort", 32'h1, {31'h0, txd});
      repeat (60) @(posedge pclk);
      // standby returns registers to reset values
      wr(OFF_FORMAT, 8'h08);
      wr(OFF_HOLD, 8'h12);
      @(posedge pclk);
      standby <= 1'b1;
      @(posedge pclk);
      standby <= 1'b0;
      chk_rst();
      tally_and_finish();
   end
endmodule
`default_nettype wire
